// *** rtl/touch_combo_pkg.sv ***
// Constants for the multi-touch limiter and combination detector.
// Assumes a register port decoded upstream from the serial host link.
package touch_combo_pkg;

  // Register offsets
  localparam logic [7:0] OFS_LIMIT_CFG  = 8'h2a;
  localparam logic [7:0] OFS_COMBO_CFG  = 8'h2b;
  localparam logic [7:0] OFS_COMBO_MASK = 8'h2d;
  localparam logic [7:0] OFS_REFRESH    = 8'h2f;
  localparam logic [7:0] OFS_THRESH_0   = 8'h30;
  localparam logic [7:0] OFS_THRESH_5   = 8'h35;

  // Reset values
  localparam logic [7:0] RST_LIMIT_CFG  = 8'h80;
  localparam logic [7:0] RST_COMBO_CFG  = 8'h00;
  localparam logic [7:0] RST_COMBO_MASK = 8'h3f;
  localparam logic [7:0] RST_REFRESH    = 8'h8a;
  localparam logic [6:0] RST_THRESH     = 7'h40;

  // Writable bits; the rest read as zero
  localparam logic [7:0] WMASK_LIMIT_CFG  = 8'h8c;
  localparam logic [7:0] WMASK_COMBO_CFG  = 8'h8f;
  localparam logic [7:0] WMASK_COMBO_MASK = 8'h3f;
  localparam logic [7:0] WMASK_REFRESH    = 8'hff;

  // Field positions
  localparam int BIT_BLOCK_EN    = 7;
  localparam int LSB_LIMIT       = 2;
  localparam int BIT_COMBO_EN    = 7;
  localparam int LSB_COMBO_FRAC  = 2;
  localparam int BIT_MATCH_SEL   = 1;
  localparam int BIT_COMBO_IRQ   = 0;
  localparam int BIT_BCAST       = 7;
  localparam int BIT_KEEP_PSUM   = 6;
  localparam int BIT_KEEP_NEGRUN = 5;
  localparam int LSB_NEGRUN_LEN  = 3;
  localparam int LSB_RECAL_CFG   = 0;

  // Negative run lengths; zero means disabled
  localparam logic [5:0] NEGRUN_8   = 6'h08;
  localparam logic [5:0] NEGRUN_16  = 6'h10;
  localparam logic [5:0] NEGRUN_32  = 6'h20;
  localparam logic [5:0] NEGRUN_OFF = 6'h00;

  localparam logic [8:0]  RECAL_SAMPLES_MAX = 9'h100;
  localparam logic [12:0] RECAL_INTERVAL_5  = 13'h0400;
  localparam logic [12:0] RECAL_INTERVAL_6  = 13'h0800;
  localparam logic [12:0] RECAL_INTERVAL_7  = 13'h1000;
  localparam logic [8:0]  RECAL_SAMPLES_MIN  = 9'h010;
  localparam logic [12:0] RECAL_INTERVAL_MIN = 13'h0010;
  localparam logic [8:0]  RST_RECAL_SAMPLES  = 9'h040;
  localparam logic [12:0] RST_RECAL_INTERVAL = 13'h0040;

endpackage

// *** rtl/touch_combo_detect.sv ***
// Touch limiter, combination detector and recalibration controls.
// Assumes one-cycle poll_done marking a complete polling cycle of results
// and a register port driven by the serial host interface decoder.
`timescale 1ns/1ps

module touch_combo_detect
  import touch_combo_pkg::*;
#(
  parameter int N_IN = 6,
  parameter int DW   = 8
)(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              reg_wr_en,
  input  wire logic              reg_rd_en,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  input  wire logic              poll_done,
  input  wire logic [N_IN-1:0]   touch_raw,
  input  wire logic [N_IN*DW-1:0] delta_flat,
  input  wire logic [N_IN-1:0]   noise_flag,
  input  wire logic              standby_mode,
  input  wire logic [6:0]        standby_thresh,
  input  wire logic              noise_status,
  input  wire logic              int_clear,
  output logic      [N_IN-1:0]   touch_report,
  output logic                   excess_touch_flag,
  output logic                   combo_event_flag,
  output logic                   alert_n,
  output logic                   partial_sum_clear,
  output logic                   neg_run_clear,
  output logic      [5:0]        neg_run_limit,
  output logic      [8:0]        recal_samples,
  output logic      [12:0]       recal_interval
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [2:0] popcnt(input logic [N_IN-1:0] v);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 0; i < N_IN; i++)
      c = c + {2'h0, v[i]};
    return c;
  endfunction

  // Lowest-numbered inputs first, at most n of them
  function automatic logic [N_IN-1:0] pick_first(input logic [N_IN-1:0] v,
                                                  input logic [2:0] n);
    logic [2:0]      c;
    logic [N_IN-1:0] p;
    c = 3'h0;
    p = '0;
    for (int i = 0; i < N_IN; i++)
      if (v[i] && c < n)
      begin
        p[i] = 1'b1;
        c    = c + 3'h1;
      end
    return p;
  endfunction

  function automatic logic [6:0] frac_of(input logic [6:0] t, input logic [1:0] code);
    logic [6:0] r;
    unique case (code)
      2'h0: r = t >> 3;
      2'h1: r = t >> 2;
      2'h2: r = (t >> 2) + (t >> 3);
      2'h3: r = t;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [7:0]      limit_cfg_r;
  logic [7:0]      combo_cfg_r;
  logic [7:0]      combo_mask_r;
  logic [7:0]      refresh_r;
  logic [6:0]      thresh_r [N_IN];

  wire wr_limit = reg_wr_en && reg_addr == OFS_LIMIT_CFG;
  wire wr_cfg   = reg_wr_en && reg_addr == OFS_COMBO_CFG;
  wire wr_mask  = reg_wr_en && reg_addr == OFS_COMBO_MASK;
  wire wr_refr  = reg_wr_en && reg_addr == OFS_REFRESH;

  wire             touch_block_enable  = limit_cfg_r[BIT_BLOCK_EN];
  wire [1:0]       simultaneous_touch_limit = limit_cfg_r[LSB_LIMIT +: 2];
  wire [2:0]       limit_n = {1'b0, simultaneous_touch_limit} + 3'h1;
  wire             combo_detect_enable = combo_cfg_r[BIT_COMBO_EN];
  wire [1:0]       combo_threshold_fraction = combo_cfg_r[LSB_COMBO_FRAC +: 2];
  wire             combo_match_select  = combo_cfg_r[BIT_MATCH_SEL];
  wire             combo_irq_enable    = combo_cfg_r[BIT_COMBO_IRQ];
  wire [N_IN-1:0]  input_in_combo      = combo_mask_r[N_IN-1:0];
  wire             broadcast_threshold_write  = refresh_r[BIT_BCAST];
  wire             keep_partial_sum_on_noise  = refresh_r[BIT_KEEP_PSUM];
  wire             keep_negative_run_on_noise = refresh_r[BIT_KEEP_NEGRUN];
  wire [1:0]       negative_run_length = refresh_r[LSB_NEGRUN_LEN +: 2];
  wire [2:0]       recal_cfg = refresh_r[LSB_RECAL_CFG +: 3];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      limit_cfg_r  <= RST_LIMIT_CFG;
      combo_cfg_r  <= RST_COMBO_CFG;
      combo_mask_r <= RST_COMBO_MASK;
      refresh_r    <= RST_REFRESH;
    end
    else
    begin
      if (wr_limit) limit_cfg_r  <= reg_wdata & WMASK_LIMIT_CFG;
      if (wr_cfg)   combo_cfg_r  <= reg_wdata & WMASK_COMBO_CFG;
      if (wr_mask)  combo_mask_r <= reg_wdata & WMASK_COMBO_MASK;
      if (wr_refr)  refresh_r    <= reg_wdata & WMASK_REFRESH;
    end
  end

  // Input 0 broadcasts when enabled; the others stay individually writable
  genvar g;
  generate
    for (g = 0; g < N_IN; g++)
    begin : g_thr
      wire own_wr = reg_wr_en && reg_addr == OFS_THRESH_0 + 8'(g);
      wire bc_wr  = reg_wr_en && reg_addr == OFS_THRESH_0 && broadcast_threshold_write;
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          thresh_r[g] <= RST_THRESH;
        else if (own_wr || bc_wr)
          thresh_r[g] <= reg_wdata[6:0];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Register read

  wire        in_thr   = reg_addr >= OFS_THRESH_0 && reg_addr <= OFS_THRESH_5;
  wire [2:0]  thr_idx  = 3'(reg_addr - OFS_THRESH_0);
  wire [7:0]  rd_mux   = (reg_addr == OFS_LIMIT_CFG)  ? limit_cfg_r  :
                         (reg_addr == OFS_COMBO_CFG)  ? combo_cfg_r  :
                         (reg_addr == OFS_COMBO_MASK) ? combo_mask_r :
                         (reg_addr == OFS_REFRESH)    ? refresh_r    :
                         in_thr ? {1'b0, thresh_r[thr_idx]} : 8'h00;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_rd_en)
      reg_rdata <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////
  // Combination detection

  wire  [N_IN-1:0] above;
  generate
    for (g = 0; g < N_IN; g++)
    begin : g_cmp
      // Standby compares against the shared standby threshold
      wire [6:0] base = standby_mode ? standby_thresh : thresh_r[g];
      wire [6:0] cthr = frac_of(base, combo_threshold_fraction);
      assign above[g] = (delta_flat[g*DW +: DW] > DW'(cthr)) || noise_flag[g];
    end
  endgenerate

  wire pattern_hit = &(above | ~input_in_combo);
  wire count_hit   = popcnt(above) >= popcnt(input_in_combo);
  wire combo_hit   = combo_detect_enable &&
                     (combo_match_select ? pattern_hit : count_hit);

  logic combo_active_r;
  // Only sampled on poll_done, so one polling cycle's results at a time
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      combo_active_r <= 1'b0;
    else if (poll_done)
      combo_active_r <= combo_hit;
  end

  // Set beats clear; clear only once the condition has gone
  wire combo_set  = poll_done && combo_hit;
  wire combo_clr  = int_clear && !combo_active_r;
  wire combo_flag_nxt = combo_set || (combo_event_flag && !combo_clr);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      combo_event_flag <= 1'b0;
      alert_n          <= 1'b1;
    end
    else
    begin
      combo_event_flag <= combo_flag_nxt;
      alert_n          <= !(combo_flag_nxt && combo_irq_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Simultaneous touch limiting

  logic [N_IN-1:0] valid_r;
  wire released  = |(valid_r & ~touch_raw);
  wire [2:0] held = popcnt(valid_r);
  wire [2:0] room = (held >= limit_n) ? 3'h0 : 3'(limit_n - held);
  wire       over = held > limit_n;
  // A release, or a limit lowered below the held set, reselects in scan order
  wire [N_IN-1:0] valid_nxt = (released || over) ? pick_first(touch_raw, limit_n)
                            : valid_r | pick_first(touch_raw & ~valid_r, room);
  wire [N_IN-1:0] report_nxt = combo_hit ? '0 :
                               touch_block_enable ? valid_nxt : touch_raw;
  wire excess_nxt = touch_block_enable && !combo_hit && |(touch_raw & ~valid_nxt);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      valid_r           <= '0;
      touch_report      <= '0;
      excess_touch_flag <= 1'b0;
    end
    else if (poll_done)
    begin
      valid_r           <= touch_block_enable ? valid_nxt : '0;
      touch_report      <= report_nxt;
      excess_touch_flag <= excess_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Recalibration controls; each keep bit gates only its own clear

  wire [5:0] negrun_dec = (negative_run_length == 2'h0) ? NEGRUN_8  :
                          (negative_run_length == 2'h1) ? NEGRUN_16 :
                          (negative_run_length == 2'h2) ? NEGRUN_32 : NEGRUN_OFF;
  wire [8:0]  samp_dec = (recal_cfg < 3'h4) ? (RECAL_SAMPLES_MIN << recal_cfg)
                                             : RECAL_SAMPLES_MAX;
  wire [12:0] intv_dec = (recal_cfg < 3'h5) ? (RECAL_INTERVAL_MIN << recal_cfg) :
                         (recal_cfg == 3'h5) ? RECAL_INTERVAL_5 :
                         (recal_cfg == 3'h6) ? RECAL_INTERVAL_6 : RECAL_INTERVAL_7;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      partial_sum_clear <= 1'b0;
      neg_run_clear     <= 1'b0;
      neg_run_limit     <= NEGRUN_16;
      recal_samples     <= RST_RECAL_SAMPLES;
      recal_interval    <= RST_RECAL_INTERVAL;
    end
    else
    begin
      partial_sum_clear <= noise_status && !keep_partial_sum_on_noise;
      neg_run_clear     <= noise_status && !keep_negative_run_on_noise;
      neg_run_limit     <= negrun_dec;
      recal_samples     <= samp_dec;
      recal_interval    <= intv_dec;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_combo_seen;
    poll_done && combo_hit;
  endsequence

  sequence s_blocked_out;
    combo_event_flag && touch_report == '0;
  endsequence

  a_block_off_pass: assert property (@(posedge clk) disable iff (sys_rst)
    poll_done && !touch_block_enable && !combo_hit |=> touch_report == $past(touch_raw))
    else $error("unblocked touches not passed through");

  a_limit_count: assert property (@(posedge clk) disable iff (sys_rst)
    poll_done && touch_block_enable |=> popcnt(touch_report) <= $past(limit_n))
    else $error("reported touches exceed limit");

  a_excess_flag: assert property (@(posedge clk) disable iff (sys_rst)
    poll_done && touch_block_enable && !combo_hit && popcnt(touch_raw) > limit_n
    |=> excess_touch_flag)
    else $error("excess touch not flagged");

  a_combo_off: assert property (@(posedge clk) disable iff (sys_rst)
    poll_done && !combo_detect_enable && !combo_event_flag |=> !combo_event_flag && alert_n)
    else $error("combination flagged while disabled");

  a_combo_block: assert property (@(posedge clk) disable iff (sys_rst)
    s_combo_seen |=> s_blocked_out)
    else $error("combination event did not flag and block");

  a_combo_hold: assert property (@(posedge clk) disable iff (sys_rst)
    combo_event_flag && combo_active_r |=> combo_event_flag)
    else $error("combination flag cleared while condition held");

  a_alert_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !combo_irq_enable |=> alert_n)
    else $error("alert driven with interrupt disabled");

  a_bcast_copy: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr_en && reg_addr == OFS_THRESH_0 && broadcast_threshold_write
    |=> thresh_r[N_IN-1] == $past(reg_wdata[6:0]) && thresh_r[1] == thresh_r[0])
    else $error("broadcast threshold not copied");

  a_psum_clear: assert property (@(posedge clk) disable iff (sys_rst)
    noise_status && !keep_partial_sum_on_noise |=> partial_sum_clear)
    else $error("partial sum not cleared on noise");

endmodule

// *** dv/reg_host.sv ***
// Host model driving the register port and the flag clear strobe.
// Assumes a free running clk and sys_rst released before the first call.
`timescale 1ns/1ps

module reg_host (
  input  wire logic       clk,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            int_clear,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    int_clear = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Released lines show the inverse so a stale value never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    reg_addr  <= ~a;
    #1;
    d = reg_rdata;
  endtask

  // One-cycle int_clear strobe to the interrupt flag; it clears only once the condition ended
  task automatic clr();
    @(posedge clk);
    int_clear <= 1'b1;
    @(posedge clk);
    int_clear <= 1'b0;
  endtask
endmodule

// *** dv/multi_touch_block_and_combo_detect_tb.sv ***
// Self-checking bench for the touch limiter and combination detector.
// Assumes the reg_host model owns the register port and flag clear.
`timescale 1ns/1ps

module multi_touch_block_and_combo_detect_tb
  import touch_combo_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        poll_done = 1'b0;
  logic [5:0]  touch_raw = 6'h00;
  logic [47:0] delta_flat = 48'h0;
  logic [5:0]  noise_flag = 6'h00;
  logic        standby_mode = 1'b0;
  logic [6:0]  standby_thresh = 7'h00;
  logic        noise_status = 1'b0;
  logic        reg_wr_en, reg_rd_en, int_clear, excess_touch_flag, combo_event_flag;
  logic        alert_n, partial_sum_clear, neg_run_clear;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [5:0]  touch_report, neg_run_limit;
  logic [8:0]  recal_samples;
  logic [12:0] recal_interval;
  int          num_errors = 0;
  int          checks = 0;

  always #2.5 clk = ~clk;

  touch_combo_detect uut (.clk(clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .poll_done(poll_done), .touch_raw(touch_raw),
    .delta_flat(delta_flat), .noise_flag(noise_flag), .standby_mode(standby_mode),
    .standby_thresh(standby_thresh), .noise_status(noise_status),
    .int_clear(int_clear), .touch_report(touch_report),
    .excess_touch_flag(excess_touch_flag), .combo_event_flag(combo_event_flag),
    .alert_n(alert_n), .partial_sum_clear(partial_sum_clear),
    .neg_run_clear(neg_run_clear), .neg_run_limit(neg_run_limit),
    .recal_samples(recal_samples), .recal_interval(recal_interval));

  reg_host host (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .int_clear(int_clear),
    .reg_rdata(reg_rdata));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.rd(a, v);
    chk($sformatf("reg %h", a), 13'(v), 13'(e));
  endtask

  // Inputs flip after the poll edge; they must be ignored then
  task automatic poll(input logic [5:0] t, input logic [5:0] nf, input logic [47:0] d);
    @(posedge clk);
    poll_done  <= 1'b1;
    touch_raw  <= t;
    noise_flag <= nf;
    delta_flat <= d;
    @(posedge clk);
    poll_done  <= 1'b0;
    touch_raw  <= ~t;
    noise_flag <= ~nf;
    delta_flat <= ~d;
    #1;
  endtask

  task automatic clear_flag();
    poll(6'h00, 6'h00, 48'h0);
    host.clr();
    @(posedge clk);
    #1;
    chk("combo flag", combo_event_flag, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk(OFS_LIMIT_CFG, 8'h80);
    rdchk(OFS_COMBO_CFG, 8'h00);
    rdchk(OFS_COMBO_MASK, 8'h3f);
    rdchk(OFS_REFRESH, 8'h8a);
    chk("neg limit", neg_run_limit, 6'h10);
    chk("samples", recal_samples, 9'h040);
    chk("interval", recal_interval, 13'h0040);
    rdchk(OFS_THRESH_5, 8'h40);
    chk("report", touch_report, 6'h00);
    chk("alert_n", alert_n, 1'b1);
    host.wr(OFS_LIMIT_CFG, 8'hff);
    rdchk(OFS_LIMIT_CFG, 8'h8c);
    host.wr(8'h2c, 8'h55);
    rdchk(8'h2c, 8'h00);
    host.wr(OFS_LIMIT_CFG, 8'h80);
  endtask

  task automatic t_limit();
    poll(6'h03, 6'h00, 48'h0);
    chk("report", touch_report, 6'h01);
    chk("excess", excess_touch_flag, 1'b1);
    poll(6'h02, 6'h00, 48'h0);
    chk("report", touch_report, 6'h02);
    chk("excess", excess_touch_flag, 1'b0);
    poll(6'h03, 6'h00, 48'h0);
    chk("report", touch_report, 6'h02);
    host.wr(OFS_LIMIT_CFG, 8'h84);
    poll(6'h07, 6'h00, 48'h0);
    chk("report", touch_report, 6'h03);
    chk("excess", excess_touch_flag, 1'b1);
    // Lowered limit must trim the held set
    host.wr(OFS_LIMIT_CFG, 8'h80);
    poll(6'h07, 6'h00, 48'h0);
    chk("report", touch_report, 6'h01);
    host.wr(OFS_LIMIT_CFG, 8'h8c);
    poll(6'h3f, 6'h00, 48'h0);
    chk("report", touch_report, 6'h0f);
    chk("excess", excess_touch_flag, 1'b1);
    host.wr(OFS_LIMIT_CFG, 8'h00);
    poll(6'h3f, 6'h00, 48'h0);
    chk("report", touch_report, 6'h3f);
    chk("excess", excess_touch_flag, 1'b0);
    host.wr(OFS_LIMIT_CFG, 8'h80);
    poll(6'h00, 6'h00, 48'h0);
  endtask

  task automatic t_pattern();
    host.wr(OFS_COMBO_MASK, 8'h03);
    host.wr(OFS_COMBO_CFG, 8'h83);
    poll(6'h01, 6'h02, 48'h09);
    chk("combo flag", combo_event_flag, 1'b1);
    chk("report", touch_report, 6'h00);
    chk("alert_n", alert_n, 1'b0);
    host.clr();
    @(posedge clk);
    #1;
    chk("combo flag", combo_event_flag, 1'b1);
    poll(6'h01, 6'h00, 48'h08);
    chk("report", touch_report, 6'h01);
    chk("combo flag", combo_event_flag, 1'b1);
    clear_flag();
    chk("alert_n", alert_n, 1'b1);
  endtask

  task automatic t_fraction();
    logic [7:0] thr;
    host.wr(OFS_COMBO_MASK, 8'h01);
    for (int c = 0; c < 4; c++)
    begin
      thr = (c == 3) ? 8'h40 : 8'(8 * (c + 1));
      host.wr(OFS_COMBO_CFG, 8'h82 | 8'(c << 2));
      poll(6'h00, 6'h00, {40'h0, thr});
      chk("combo flag", combo_event_flag, 1'b0);
      poll(6'h00, 6'h00, {40'h0, thr + 8'h01});
      chk("combo flag", combo_event_flag, 1'b1);
      chk("alert_n", alert_n, 1'b1);
      clear_flag();
    end
    host.wr(OFS_COMBO_CFG, 8'h02);
    poll(6'h00, 6'h01, 48'hff);
    chk("combo flag", combo_event_flag, 1'b0);
  endtask

  task automatic t_count();
    host.wr(OFS_COMBO_MASK, 8'h07);
    host.wr(OFS_COMBO_CFG, 8'h8c);
    poll(6'h00, 6'h20, 48'h004141000000);
    chk("combo flag", combo_event_flag, 1'b1);
    clear_flag();
    poll(6'h00, 6'h00, 48'h004141000000);
    chk("combo flag", combo_event_flag, 1'b0);
    @(posedge clk);
    standby_mode   <= 1'b1;
    standby_thresh <= 7'h20;
    host.wr(OFS_COMBO_MASK, 8'h01);
    host.wr(OFS_COMBO_CFG, 8'h8e);
    poll(6'h00, 6'h00, 48'h20);
    chk("combo flag", combo_event_flag, 1'b0);
    poll(6'h00, 6'h00, 48'h21);
    chk("combo flag", combo_event_flag, 1'b1);
    @(posedge clk);
    standby_mode <= 1'b0;
    clear_flag();
    host.wr(OFS_COMBO_CFG, 8'h00);
  endtask

  task automatic t_bcast();
    host.wr(OFS_THRESH_0, 8'h15);
    rdchk(OFS_THRESH_5, 8'h15);
    host.wr(8'h33, 8'h22);
    rdchk(8'h33, 8'h22);
    rdchk(OFS_THRESH_0, 8'h15);
    host.wr(OFS_REFRESH, 8'h0a);
    host.wr(OFS_THRESH_0, 8'hff);
    rdchk(8'h31, 8'h15);
    rdchk(OFS_THRESH_0, 8'h7f);
  endtask

  task automatic t_recal();
    @(posedge clk);
    noise_status <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      host.wr(OFS_REFRESH, 8'((i % 4) << 3) | 8'(i));
      repeat (2) @(posedge clk);
      #1;
      chk("neg limit", neg_run_limit, (i % 4 == 3) ? 13'h0 : 13'(8 << (i % 4)));
      chk("samples", recal_samples, (i < 4) ? 13'(16 << i) : 13'h100);
      chk("interval", recal_interval, (i < 5) ? 13'(16 << i) : 13'(1024 << (i - 5)));
      chk("psum clear", partial_sum_clear, 1'b1);
      chk("negrun clear", neg_run_clear, 1'b1);
    end
    // Both keep bits programmed alike
    host.wr(OFS_REFRESH, 8'h6a);
    repeat (2) @(posedge clk);
    #1;
    chk("psum clear", partial_sum_clear, 1'b0);
    chk("negrun clear", neg_run_clear, 1'b0);
    // Without noise nothing is cleared
    @(posedge clk);
    noise_status <= 1'b0;
    host.wr(OFS_REFRESH, 8'h0a);
    repeat (2) @(posedge clk);
    #1;
    chk("psum clear", partial_sum_clear, 1'b0);
    chk("negrun clear", neg_run_clear, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #40000;
    num_errors++;
    stop_test();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_limit();
    t_pattern();
    t_fraction();
    t_count();
    t_bcast();
    t_recal();
    stop_test();
  end
endmodule
